// ### core/csrp_pkg.sv
// Purpose: Shared constants, types and helpers for the converter serial register port.
// Assumes: Both ends import this package; the link interface does not.
// Notes: Register select codes and command-byte layout are fixed here once.
package csrp_pkg;

	// ----------------------------------------------------------------
	// Command byte layout and transfer lengths.
	// ----------------------------------------------------------------
	localparam int CMD_RDY_BIT = 7; // Result-ready copy on read.
	localparam int CMD_RS_LSB = 4; // Register select, three bits.
	localparam int CMD_RW_BIT = 3; // One selects a read.
	localparam int CMD_STBY_BIT = 2; // Standby request.
	localparam int CMD_CH_LSB = 0; // Channel select, two bits.
	localparam logic [4:0] CMD_LEN = 5'h08;
	localparam logic [4:0] CFG_LEN = 5'h08;
	localparam logic [4:0] DATA_LEN = 5'h10;
	localparam logic [4:0] CAL_LEN = 5'h18;
	localparam int ONES_RUN = 32; // Ones on the input that resync the port.
	localparam logic [5:0] ONES_LAST = 6'(ONES_RUN - 1);

	// ----------------------------------------------------------------
	// Reset values and timing counts.
	// ----------------------------------------------------------------
	localparam logic [7:0] COMM_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [7:0] CLOCK_RST = 8'h00;
	localparam logic [23:0] ZERO_RST = 24'h000000;
	localparam logic [23:0] FULL_RST = 24'h000000;
	localparam logic [5:0] UPD_WARN_CYC = 6'h10; // Ready stays high this long before a load.
	localparam logic [2:0] SCLK_HALF = 3'h4; // Host core cycles per half serial clock.

	// Register select codes carried in the command byte.
	typedef enum logic [2:0] {
		RS_COMM = 3'h0,
		RS_SETUP = 3'h1,
		RS_CLOCK = 3'h2,
		RS_DATA = 3'h3,
		RS_TEST = 3'h4,
		RS_NONE = 3'h5,
		RS_ZERO = 3'h6,
		RS_FULL = 3'h7
	} csrp_rsel_t;

	// Number of bits in the transfer that follows a command.
	function automatic logic [4:0] reg_len(input csrp_rsel_t sel);
		unique case (sel)
			RS_DATA: reg_len = DATA_LEN;
			RS_ZERO, RS_FULL: reg_len = CAL_LEN;
			default: reg_len = CFG_LEN;
		endcase
	endfunction

	// Left-justify a right-aligned word of the given length in 24 bits.
	function automatic logic [23:0] align(input logic [23:0] val, input logic [4:0] len);
		unique case (len)
			CFG_LEN: align = {val[7:0], 16'h0000};
			DATA_LEN: align = {val[15:0], 8'h00};
			default: align = val;
		endcase
	endfunction

	// Two-bit gray sequence step, safe to pass between clock domains.
	function automatic logic [1:0] gray_next(input logic [1:0] g);
		unique case (g)
			2'h0: gray_next = 2'h1;
			2'h1: gray_next = 2'h3;
			2'h3: gray_next = 2'h2;
			default: gray_next = 2'h0;
		endcase
	endfunction

endpackage

// ### core/csrp_link_if.sv
// Purpose: Wires of the serial port between the host and the converter.
// Assumes: The host makes the serial clock; the converter drives its output and ready line.
// Notes: The output line idles high while the converter is not selected, like a pull-up.
`timescale 1ns/1ps
interface csrp_link_if;
	logic sclk; // Serial clock from the host.
	logic cs_n; // Device select, active low.
	logic din; // Data into the converter.
	logic dout; // Data driven by the converter.
	logic result_ready_n; // Unread conversion word, active low.
	logic dout_line; // Level seen on the output wire.

	// The converter only drives the wire while selected.
	assign dout_line = cs_n ? 1'b1 : dout;

	modport device (
		input sclk,
		input cs_n,
		input din,
		output dout,
		output result_ready_n
	);

	modport host (
		output sclk,
		output cs_n,
		output din,
		input dout_line,
		input result_ready_n
	);
endinterface

// ### core/csrp_device.sv
// Purpose: Converter end of the serial register port with its register file.
// Assumes: Link logic runs on the host serial clock; results arrive on core_clk_i.
// Notes: Config words cross by gray sequence; result word by a gray load count over a stable word.
`timescale 1ns/1ps

module csrp_device
	import csrp_pkg::*;
(
	input wire logic core_clk_i, // Converter core clock.
	input wire logic resetn_i, // Hardware reset, active low.
	input wire logic conv_valid_i, // One-cycle pulse: a new conversion word.
	input wire logic [15:0] conv_word_i, // The new conversion word.
	output logic [7:0] setup_o, // Setup register as last written.
	output logic [7:0] clock_o, // Clock register as last written.
	output logic [23:0] zero_cal_o, // Zero-scale calibration word.
	output logic [23:0] full_cal_o, // Full-scale calibration word.
	output logic [1:0] channel_o, // Channel select from the command byte.
	output logic standby_o, // Standby request from the command byte.
	csrp_link_if.device link // Serial pins.
);

	// ----------------------------------------------------------------
	// State types.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		L_CMD = 2'b00,
		L_WR = 2'b01,
		L_RD = 2'b10
	} csrp_lstate_t;

	// Link-domain state, clocked by the serial clock.
	typedef struct packed {
		csrp_lstate_t st; // Transfer phase.
		logic [4:0] cnt; // Bits moved in this phase.
		logic [4:0] len; // Bits in the selected register.
		csrp_rsel_t sel; // Register selected by the last command.
		logic [23:0] sh; // Shift register, both directions.
		logic [5:0] ones; // Run of ones seen on the input.
		logic [7:0] comm; // Last command byte.
		logic [7:0] setup; // Setup register.
		logic [7:0] clk; // Clock register.
		logic [23:0] zero; // Zero-scale calibration.
		logic [23:0] full; // Full-scale calibration.
		logic [15:0] word; // Snapshot of the result word.
		logic [1:0] rdy_s; // Ready level synchroniser.
		logic [3:0] upd_s; // Load count synchroniser, two 2-bit stages.
		logic [1:0] upd_p; // Load count last acted on.
		logic [1:0] cfg_seq; // Gray count of configuration writes.
		logic rd_t; // Toggles when a result read completes.
	} csrp_link_t;

	// Core-domain state.
	typedef struct packed {
		logic [7:0] setup;
		logic [7:0] clk;
		logic [23:0] zero;
		logic [23:0] full;
		logic [1:0] chan;
		logic stby;
		logic [15:0] data; // Output register holding the result.
		logic [15:0] pend; // Word waiting for its load.
		logic busy; // Update in progress.
		logic [5:0] warn; // Cycles left before the load.
		logic rdy_n; // Result-ready, active low.
		logic [1:0] upd_t; // Gray count of loads, so two loads between serial clocks still show.
		logic [3:0] seq_s; // Config sequence synchroniser, two 2-bit stages.
		logic [1:0] seq_p; // Config sequence last copied.
		logic [1:0] rd_s; // Read-done toggle synchroniser.
		logic rd_p; // Previous synchronised read toggle.
	} csrp_core_t;

	csrp_link_t l_reg;
	csrp_link_t l_next;
	csrp_core_t c_reg;
	csrp_core_t c_next;
	logic dout_reg; // Output bit, changes on falling edges.

	// Value shown by a read of the selected register.
	function automatic logic [23:0] read_val(input csrp_link_t s);
		unique case (s.sel)
			RS_COMM: read_val = {16'h0000, s.rdy_s[1], s.comm[6:0]};
			RS_SETUP: read_val = {16'h0000, s.setup};
			RS_CLOCK: read_val = {16'h0000, s.clk};
			RS_DATA: read_val = {8'h00, s.word};
			RS_ZERO: read_val = s.zero;
			RS_FULL: read_val = s.full;
			default: read_val = 24'h000000;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Link side.
	// ----------------------------------------------------------------

	// Next link state. The transfer moves only while select is low; the synchronisers always step.
	always_comb begin
		logic [7:0] cmd;
		logic [23:0] win;
		cmd = {l_reg.sh[6:0], link.din};
		win = {l_reg.sh[22:0], link.din};
		l_next = l_reg;
		l_next.rdy_s = {l_reg.rdy_s[0], c_reg.rdy_n};
		l_next.upd_s = {l_reg.upd_s[1:0], c_reg.upd_t};
		l_next.upd_p = l_reg.upd_s[3:2];
		// The core word is held still around its count step, so copying it is safe.
		// Limitation: four loads with the serial clock stopped wrap the count unseen.
		if (l_reg.upd_s[3:2] != l_reg.upd_p) begin
			l_next.word = c_reg.data;
		end
		if (!link.cs_n) begin
			// Reads ignore the input, so read data cannot fake a resync.
			if (l_reg.st != L_RD) begin
				l_next.ones = link.din ? l_reg.ones + 6'h01 : 6'h00;
			end
			unique case (l_reg.st)
				L_CMD: begin
					l_next.sh = win;
					l_next.cnt = l_reg.cnt + 5'h01;
					if (l_reg.cnt == CMD_LEN - 5'h01) begin
						l_next.cnt = 5'h00;
					end
					// A byte with its top bit set is no command, so a run of ones never opens a read.
					if (l_reg.cnt == CMD_LEN - 5'h01 && !cmd[CMD_RDY_BIT]) begin
						l_next.comm = cmd;
						l_next.sel = csrp_rsel_t'(cmd[CMD_RS_LSB +: 3]);
						l_next.len = reg_len(csrp_rsel_t'(cmd[CMD_RS_LSB +: 3]));
						l_next.cfg_seq = gray_next(l_reg.cfg_seq);
						if (cmd[CMD_RW_BIT]) begin
							// Loaded now so the very next clock moves its MSB.
							l_next.st = L_RD;
							l_next.sel = csrp_rsel_t'(cmd[CMD_RS_LSB +: 3]);
							l_next.sh = align(read_val(l_next), l_next.len);
						end else if (csrp_rsel_t'(cmd[CMD_RS_LSB +: 3]) != RS_COMM) begin
							l_next.st = L_WR;
						end
					end
				end
				L_WR: begin
					l_next.sh = win;
					l_next.cnt = l_reg.cnt + 5'h01;
					if (l_reg.cnt == l_reg.len - 5'h01) begin
						l_next.st = L_CMD;
						l_next.cnt = 5'h00;
						l_next.cfg_seq = gray_next(l_reg.cfg_seq);
						unique case (l_reg.sel)
							RS_SETUP: l_next.setup = win[7:0];
							RS_CLOCK: l_next.clk = win[7:0];
							RS_ZERO: l_next.zero = win;
							RS_FULL: l_next.full = win;
							default: l_next.cfg_seq = l_reg.cfg_seq; // Read-only or empty slot.
						endcase
					end
				end
				default: begin // L_RD
					l_next.sh = {l_reg.sh[22:0], 1'b0};
					l_next.cnt = l_reg.cnt + 5'h01;
					if (l_reg.cnt == l_reg.len - 5'h01) begin
						l_next.st = L_CMD;
						l_next.cnt = 5'h00;
						if (l_reg.sel == RS_DATA) begin
							l_next.rd_t = ~l_reg.rd_t;
						end
					end
				end
			endcase
			// A full run of ones drops a command or write transfer, never a read, but keeps every register.
			if (l_reg.st != L_RD && link.din && l_reg.ones == ONES_LAST) begin
				l_next.st = L_CMD;
				l_next.cnt = 5'h00;
				l_next.ones = 6'h00;
				l_next.cfg_seq = l_reg.cfg_seq;
				l_next.comm = l_reg.comm;
				l_next.setup = l_reg.setup;
				l_next.clk = l_reg.clk;
				l_next.zero = l_reg.zero;
				l_next.full = l_reg.full;
			end
		end
	end

	// Link registers sample on the rising serial clock edge.
	always_ff @(posedge link.sclk or negedge resetn_i) begin
		if (!resetn_i) begin
			l_reg <= '{st: L_CMD, sel: RS_COMM, comm: COMM_RST, setup: SETUP_RST, clk: CLOCK_RST,
				zero: ZERO_RST, full: FULL_RST, rdy_s: 2'h3, default: '0};
		end else begin
			l_reg <= l_next;
		end
	end

	// Output bit moves after the falling edge. It shows the shifter MSB only in a read and ones
	// otherwise, so the read MSB first reaches the wire at the falling edge after the command byte.
	always_ff @(negedge link.sclk or negedge resetn_i) begin
		if (!resetn_i) begin
			dout_reg <= 1'b1;
		end else begin
			dout_reg <= (l_reg.st == L_RD) ? l_reg.sh[23] : 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Core side.
	// ----------------------------------------------------------------

	// Result loading, ready line and config mirror.
	always_comb begin
		c_next = c_reg;
		c_next.seq_s = {c_reg.seq_s[1:0], l_reg.cfg_seq};
		c_next.rd_s = {c_reg.rd_s[0], l_reg.rd_t};
		c_next.rd_p = c_reg.rd_s[1];
		// A later write re-triggers the copy, so skew settles out.
		if (c_reg.seq_s[3:2] != c_reg.seq_p) begin
			c_next.seq_p = c_reg.seq_s[3:2];
			c_next.setup = l_reg.setup;
			c_next.clk = l_reg.clk;
			c_next.zero = l_reg.zero;
			c_next.full = l_reg.full;
			c_next.chan = l_reg.comm[CMD_CH_LSB +: 2];
			c_next.stby = l_reg.comm[CMD_STBY_BIT];
		end
		// The word stays put after the read, so it may be read again.
		if (c_reg.rd_s[1] != c_reg.rd_p) begin
			c_next.rdy_n = 1'b1;
		end
		if (conv_valid_i) begin
			c_next.pend = conv_word_i;
			c_next.busy = 1'b1;
			c_next.warn = UPD_WARN_CYC;
			c_next.rdy_n = 1'b1;
		end else if (c_reg.busy) begin
			c_next.warn = c_reg.warn - 6'h01;
			if (c_reg.warn == 6'h01) begin
				// Load wins over a read clear in the same cycle.
				c_next.busy = 1'b0;
				c_next.data = c_reg.pend;
				c_next.upd_t = gray_next(c_reg.upd_t);
				c_next.rdy_n = 1'b0;
			end
		end
	end

	// Core registers.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			c_reg <= '{setup: SETUP_RST, clk: CLOCK_RST, zero: ZERO_RST, full: FULL_RST,
				rdy_n: 1'b1, default: '0};
		end else begin
			c_reg <= c_next;
		end
	end

	assign setup_o = c_reg.setup;
	assign clock_o = c_reg.clk;
	assign zero_cal_o = c_reg.zero;
	assign full_cal_o = c_reg.full;
	assign channel_o = c_reg.chan;
	assign standby_o = c_reg.stby;
	assign link.result_ready_n = c_reg.rdy_n;
	assign link.dout = dout_reg;

endmodule // csrp_device

// ### core/csrp_host.sv
// Purpose: Host end of the serial register port, one frame per request.
// Assumes: Serial clock is divided from core_clk_i and idles high.
// Notes: Output line and ready line pass two flip-flops before use.
`timescale 1ns/1ps
module csrp_host
	import csrp_pkg::*;
(
	input wire logic core_clk_i, // Host clock.
	input wire logic resetn_i, // Reset, active low.
	input wire logic req_valid_i, // Request strobe, taken while req_ready_o is high.
	input wire logic [7:0] req_cmd_i, // Command byte sent first.
	input wire logic [4:0] req_len_i, // Bits following the command, 0 to 24.
	input wire logic [23:0] req_wdata_i, // Write word, right-aligned.
	input wire logic req_resync_i, // Send a run of ones instead.
	output logic req_ready_o, // High while idle.
	output logic done_o, // One-cycle pulse at frame end.
	output logic [23:0] rdata_o, // Read word, right-aligned.
	output logic result_pending_o, // Synchronised ready line, active high.
	csrp_link_if.host link // Serial pins.
);

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LEAD = 2'b01,
		H_BIT = 2'b10,
		H_TAIL = 2'b11
	} csrp_hstate_t;

	typedef struct packed {
		csrp_hstate_t st;
		logic [2:0] half; // Core cycles in this half clock.
		logic [5:0] idx; // Rising edges so far.
		logic [5:0] total; // Bits in the frame.
		logic rd; // Frame reads after its command.
		logic [31:0] so; // Outgoing bits, MSB first.
		logic [23:0] si; // Incoming bits.
		logic sclk;
		logic cs_n;
		logic din;
		logic ready;
		logic done;
		logic [23:0] rdata;
		logic [1:0] do_s; // Output line synchroniser.
		logic [1:0] rdy_s; // Ready line synchroniser.
	} csrp_host_t;

	csrp_host_t h_reg;
	csrp_host_t h_next;

	// ----------------------------------------------------------------
	// Frame sequencer.
	// ----------------------------------------------------------------

	// One frame: select, bits changed on falling and sampled on rising, deselect.
	always_comb begin
		h_next = h_reg;
		h_next.do_s = {h_reg.do_s[0], link.dout_line};
		h_next.rdy_s = {h_reg.rdy_s[0], link.result_ready_n};
		h_next.done = 1'b0;
		h_next.half = h_reg.half + 3'h1;
		unique case (h_reg.st)
			H_IDLE: begin
				h_next.half = 3'h0;
				if (req_valid_i) begin
					h_next.st = H_LEAD;
					h_next.ready = 1'b0;
					h_next.cs_n = 1'b0;
					h_next.idx = 6'h00;
					h_next.si = 24'h000000;
					if (req_resync_i) begin
						h_next.so = 32'hFFFFFFFF;
						h_next.total = 6'(ONES_RUN);
						h_next.rd = 1'b0;
					end else begin
						// Every frame opens with its command byte.
						h_next.rd = req_cmd_i[CMD_RW_BIT];
						h_next.total = {1'b0, CMD_LEN} + {1'b0, req_len_i};
						// Idle ones on the input during a read are ignored.
						h_next.so = {req_cmd_i, req_cmd_i[CMD_RW_BIT] ? 24'hFFFFFF : align(req_wdata_i, req_len_i)};
					end
				end
			end
			H_LEAD: begin
				if (h_reg.half == SCLK_HALF - 3'h1) begin
					h_next.st = H_BIT;
					h_next.half = 3'h0;
					h_next.sclk = 1'b0;
					h_next.din = h_reg.so[31];
					h_next.so = {h_reg.so[30:0], 1'b1};
				end
			end
			H_BIT: begin
				if (h_reg.half == SCLK_HALF - 3'h1) begin
					h_next.half = 3'h0;
					if (!h_reg.sclk) begin
						h_next.sclk = 1'b1;
						h_next.idx = h_reg.idx + 6'h01;
						if (h_reg.rd && h_reg.idx >= {1'b0, CMD_LEN}) begin
							h_next.si = {h_reg.si[22:0], h_reg.do_s[1]};
						end
						if (h_reg.idx + 6'h01 == h_reg.total) begin
							h_next.st = H_TAIL;
						end
					end else begin
						h_next.sclk = 1'b0;
						h_next.din = h_reg.so[31];
						h_next.so = {h_reg.so[30:0], 1'b1};
					end
				end
			end
			default: begin // H_TAIL
				if (h_reg.half == SCLK_HALF - 3'h1) begin
					h_next.st = H_IDLE;
					h_next.cs_n = 1'b1;
					h_next.din = 1'b1;
					h_next.ready = 1'b1;
					h_next.done = 1'b1;
					h_next.rdata = h_reg.si;
				end
			end
		endcase
	end

	// Host registers. The clock rests high between frames.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			h_reg <= '{st: H_IDLE, sclk: 1'b1, cs_n: 1'b1, din: 1'b1, ready: 1'b1, do_s: 2'h3,
				rdy_s: 2'h3, default: '0};
		end else begin
			h_reg <= h_next;
		end
	end

	assign link.sclk = h_reg.sclk;
	assign link.cs_n = h_reg.cs_n;
	assign link.din = h_reg.din;
	assign req_ready_o = h_reg.ready;
	assign done_o = h_reg.done;
	assign rdata_o = h_reg.rdata;
	assign result_pending_o = ~h_reg.rdy_s[1];

endmodule // csrp_host

// ### verification/csrp_link_checker.sv
// Purpose: Link-level checks between the host end and the converter end.
// Assumes: Link wires are sampled on the core clock that the host divides into sclk.
// Notes: Small counters stand in for long repetitions.
`timescale 1ns/1ps
module csrp_link_checker
	import csrp_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic result_ready_n,
	input wire logic dout_line
);
	// ----------------------------------------------------------------
	// Helper state.
	// ----------------------------------------------------------------
	// Last clock level, rises in this frame, and how long ready has stood high.
	typedef struct packed {
		logic sclk;
		logic [5:0] rises;
		logic [5:0] high;
	} csrp_chk_t;
	csrp_chk_t st_reg, st_next;

	// The span saturates so that a long idle never wraps it back to a small value.
	always_comb begin
		st_next = st_reg;
		st_next.sclk = sclk;
		if (cs_n) begin
			st_next.rises = 6'h00;
		end else if (sclk && !st_reg.sclk) begin
			st_next.rises = st_reg.rises + 6'h01;
		end
		if (!result_ready_n) begin
			st_next.high = 6'h00;
		end else if (st_reg.high != 6'h3F) begin
			st_next.high = st_reg.high + 6'h01;
		end
	end

	// Registers the helper state.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '{sclk: 1'b1, rises: 6'h00, high: 6'h00};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_idle_clock_high: assert property (cs_n |-> sclk)
		else $error("serial clock low while deselected");
	chk_select_clock_high: assert property ($changed(cs_n) |-> sclk && $past(sclk))
		else $error("select moved while serial clock low");
	chk_half_period: assert property ($fell(sclk) |-> (!sclk)[*4] ##1 sclk)
		else $error("serial clock low phase not four cycles");
	chk_dout_after_fall: assert property ($changed(dout) |-> !sclk)
		else $error("output changed while serial clock high");
	chk_din_while_low: assert property ($changed(din) |-> !sclk || cs_n)
		else $error("input changed while serial clock high");
	chk_ready_warn_span: assert property ($fell(result_ready_n) |-> st_reg.high >= UPD_WARN_CYC - 6'h01)
		else $error("ready fell without the warning span");
	chk_cmd_output_idle: assert property (!cs_n && !sclk && st_reg.rises < 6'h08 |-> dout_line)
		else $error("output active during the command byte");
	chk_frame_whole_bytes: assert property ($rose(cs_n) |-> st_reg.rises[2:0] == 3'h0
		&& st_reg.rises != 6'h00 && st_reg.rises <= 6'h20)
		else $error("frame not a whole number of bytes");

	cov_read_frame: cover property ($rose(cs_n) && st_reg.rises == 6'h18);
	cov_resync_frame: cover property ($rose(cs_n) && st_reg.rises == 6'h20);
	cov_ready_low: cover property ($fell(result_ready_n));
endmodule // csrp_link_checker

// ### verification/tb_converter_serial_register_port.sv
// Purpose: Host end and converter end joined over the link, driven from the user sides.
// Assumes: One core clock serves both ends; the host divides it into sclk.
// Notes: Read words are noted in a queue and matched when done_o pulses.
`timescale 1ns/1ps
module tb_converter_serial_register_port
	import csrp_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus and observed signals.
	// ----------------------------------------------------------------
	logic core_clk = 1'b0, resetn = 1'b0, conv_valid = 1'b0, req_valid = 1'b0, req_resync = 1'b0;
	logic [15:0] conv_word = 16'h0000;
	logic [7:0] req_cmd = 8'h00, lfsr = 8'h3C; // Generator starts at 60.
	logic [4:0] req_len = 5'h00;
	logic [23:0] req_wdata = 24'h000000, rdata, zero_cal, full_cal;
	logic req_ready, done, pending, standby;
	logic [7:0] setup, clockr;
	logic [1:0] channel;
	logic [24:0] exp_q[$]; // Bit 24 set means the read word is compared.
	int num_errors = 0, samples_checked = 0;

	csrp_link_if csrp_link_if_i();
	csrp_device csrp_device_i(.core_clk_i(core_clk), .resetn_i(resetn), .conv_valid_i(conv_valid),
		.conv_word_i(conv_word), .setup_o(setup), .clock_o(clockr), .zero_cal_o(zero_cal),
		.full_cal_o(full_cal), .channel_o(channel), .standby_o(standby), .link(csrp_link_if_i.device));
	csrp_host csrp_host_i(.core_clk_i(core_clk), .resetn_i(resetn), .req_valid_i(req_valid),
		.req_cmd_i(req_cmd), .req_len_i(req_len), .req_wdata_i(req_wdata), .req_resync_i(req_resync),
		.req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .result_pending_o(pending),
		.link(csrp_link_if_i.host));
	csrp_link_checker csrp_link_checker_i(.core_clk_i(core_clk), .resetn_i(resetn),
		.sclk(csrp_link_if_i.sclk), .cs_n(csrp_link_if_i.cs_n), .din(csrp_link_if_i.din),
		.dout(csrp_link_if_i.dout), .result_ready_n(csrp_link_if_i.result_ready_n),
		.dout_line(csrp_link_if_i.dout_line));

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// Command byte: select, read flag, then standby and channel.
	function automatic logic [7:0] mk_cmd(input logic [2:0] sel, input logic rd, input logic [2:0] lo);
		return {1'b0, sel, rd, lo};
	endfunction

	// One step of the 8-bit generator.
	function automatic logic [7:0] lfsr_step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Three generator steps fill a fresh 24-bit value.
	task automatic get_rnd(output logic [23:0] v);
		repeat (3) begin
			lfsr = lfsr_step(lfsr);
			v = {v[15:0], lfsr};
		end
	endtask

	task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({23'h0, got}, {23'h0, exp});
	endtask

	// One frame: the request is held for the edge that takes it, then done is awaited.
	task automatic xfer(input logic [7:0] cmd, input logic [4:0] len, input logic [23:0] wd,
		input logic rs, input logic [24:0] e);
		int n;
		exp_q.push_back(e);
		@(posedge core_clk);
		req_cmd <= cmd;
		req_len <= len;
		req_wdata <= wd;
		req_resync <= rs;
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		for (n = 0; n < 600 && done !== 1'b1; n++)
			@(negedge core_clk);
		if (n == 600)
			num_errors++;
		@(posedge core_clk);
	endtask

	task automatic conv(input logic [15:0] w);
		@(posedge core_clk);
		conv_word <= w;
		conv_valid <= 1'b1;
		@(posedge core_clk);
		conv_valid <= 1'b0;
	endtask

	task automatic wait_pending(input logic lvl);
		for (int n = 0; n < 100 && pending !== lvl; n++)
			@(negedge core_clk);
		cmp_bit(pending, lvl);
	endtask

	task automatic print_verdict();
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Each done pulse takes the oldest note; write frames leave a note that skips the compare.
	always @(posedge core_clk) begin
		logic [24:0] e;
		if (done === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1FFFFFF;
			if (e[24])
				cmp_word(rdata, e[23:0]);
		end
	end

	// A hang is cut short well past the few thousand cycles the sequence needs.
	initial begin
		repeat (40000) @(posedge core_clk);
		num_errors++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		logic [23:0] v, kept;
		logic [7:0] c;
		logic [2:0] sels [4] = '{RS_SETUP, RS_CLOCK, RS_ZERO, RS_FULL};
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		// Write then read back each register; widths follow the select code.
		for (int i = 0; i < 4; i++) begin
			get_rnd(v);
			if (!sels[i][2])
				v = {16'h0000, v[7:0]};
			if (i == 0)
				kept = v;
			xfer(mk_cmd(sels[i], 1'b0, 3'h0), sels[i][2] ? CAL_LEN : CFG_LEN, v, 1'b0, 25'h0);
			xfer(mk_cmd(sels[i], 1'b1, 3'h0), sels[i][2] ? CAL_LEN : CFG_LEN, 24'h0, 1'b0, {1'b1, v});
			repeat (8) @(posedge core_clk);
			cmp_word(i == 0 ? {16'h0, setup} : i == 1 ? {16'h0, clockr} : i == 2 ? zero_cal : full_cal, v);
		end
		get_rnd(v);
		xfer(mk_cmd(RS_COMM, 1'b0, v[2:0]), 5'h00, 24'h0, 1'b0, 25'h0);
		repeat (8) @(posedge core_clk);
		cmp_word({21'h0, standby, channel}, {21'h0, v[2:0]});
		for (int i = 4; i < 6; i++)
			xfer(mk_cmd(3'(i), 1'b1, 3'h0), CFG_LEN, 24'h0, 1'b0, {1'b1, 24'h0});
		// A second word arrives while the first is unread.
		get_rnd(v);
		conv(v[15:0]);
		wait_pending(1'b1);
		get_rnd(v);
		conv(v[15:0]);
		// Long enough for the host's copy to drop, so the next wait sees the new load.
		repeat (4) @(negedge core_clk);
		cmp_bit(csrp_link_if_i.result_ready_n, 1'b1);
		cmp_bit(pending, 1'b0);
		wait_pending(1'b1);
		repeat (8) @(posedge core_clk);
		c = mk_cmd(RS_COMM, 1'b1, 3'h0);
		xfer(c, CFG_LEN, 24'h0, 1'b0, {17'h10000, 1'b0, c[6:0]});
		xfer(mk_cmd(RS_DATA, 1'b1, 3'h0), DATA_LEN, 24'h0, 1'b0, {9'h100, v[15:0]});
		wait_pending(1'b0);
		xfer(mk_cmd(RS_DATA, 1'b1, 3'h0), DATA_LEN, 24'h0, 1'b0, {9'h100, v[15:0]});
		xfer(c, CFG_LEN, 24'h0, 1'b0, {17'h10000, 1'b1, c[6:0]});
		// Lose the port mid-transaction, then recover it with a run of ones.
		xfer(mk_cmd(RS_DATA, 1'b0, 3'h0), 5'h00, 24'h0, 1'b0, 25'h0);
		xfer(8'hFF, 5'h00, 24'h0, 1'b1, 25'h0);
		xfer(mk_cmd(RS_SETUP, 1'b1, 3'h0), CFG_LEN, 24'h0, 1'b0, {1'b1, kept});
		// Configuration is written again after a recovery, then read back.
		get_rnd(v);
		xfer(mk_cmd(RS_SETUP, 1'b0, 3'h0), CFG_LEN, {16'h0000, v[7:0]}, 1'b0, 25'h0);
		xfer(mk_cmd(RS_SETUP, 1'b1, 3'h0), CFG_LEN, 24'h0, 1'b0, {9'h100, 8'h00, v[7:0]});
		// A second hardware reset in mid-run.
		resetn <= 1'b0;
		repeat (4) @(posedge core_clk);
		cmp_bit(csrp_link_if_i.result_ready_n, 1'b1);
		cmp_word({21'h0, csrp_link_if_i.cs_n, csrp_link_if_i.sclk, csrp_link_if_i.din}, 24'h7);
		resetn <= 1'b1;
		xfer(mk_cmd(RS_SETUP, 1'b1, 3'h0), CFG_LEN, 24'h0, 1'b0, {9'h100, 8'h00, SETUP_RST});
		print_verdict();
	end
endmodule // tb_converter_serial_register_port
